// File: hw/dacoc_pkg.sv
/*
 Constants for the two-instance converter output control block.
 Assumes an APB master with 32-bit data and word-aligned registers.
*/
// Contract
// - Resolution bit zero twelve bits, one eight
// - Range bit zero gives 3x, one 1x
// - Format bit picks binary or two's complement
// - Only low 8 or 12 bits drive core
// - Nonzero amp setting takes pin from port
// - Two-output pin select: general or alternate pins
// - Single-pin variant: pin select alone applies function
// - Companion reference: codes 0,1 internal; 2,3 external
// - Supply variant: codes 0,1 supply; 2,3 reference
// - Instances identical, each own registers by index
// - One or two instances, optionally grouped update
// - Load select zero: latch transparent, ignores enable
// - Load 1 write, 2/3 timer edges, needs enable
// - Nonzero load select sets sticky done flag
// - Grouped outputs wait until both data written
package dacoc_pkg;
  // -------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------
  localparam logic [11:0] CTL0_ADDR = 12'h1c0;
  localparam logic [11:0] CTL1_ADDR = 12'h1c4;
  localparam logic [11:0] DAT0_ADDR = 12'h1c8;
  localparam logic [11:0] DAT1_ADDR = 12'h1cc;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h1d0;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h1d4;
  // -------------------------------------------------------------
  // Control field positions
  // -------------------------------------------------------------
  localparam int OPS_BIT = 15;
  localparam int SREF_LSB = 13;
  localparam int RES_BIT = 12;
  localparam int LSEL_LSB = 10;
  localparam int IR_BIT = 8;
  localparam int AMP_LSB = 5;
  localparam int DF_BIT = 4;
  localparam int IE_BIT = 3;
  localparam int IFG_BIT = 2;
  localparam int ENC_BIT = 1;
  localparam int GRP_BIT = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [11:0] MASK12 = 12'hfff;
  localparam logic [11:0] MASK8 = 12'h0ff;
  localparam logic [11:0] SIGN12 = 12'h800;
  localparam logic [11:0] SIGN8 = 12'h080;
  localparam logic [1:0] LSEL_NONE = 2'h0;
  localparam logic [1:0] LSEL_WRITE = 2'h1;
  localparam logic [1:0] LSEL_TMR1 = 2'h2;
  localparam logic [1:0] LSEL_TMR2 = 2'h3;
  localparam int NUM_INST = 2;
endpackage : dacoc_pkg

// File: hw/dacoc_chan_if.sv
/*
 Interface carrying one converter instance's settings and events.
 Assumes the top drives control and the channel returns latch state.
*/
`timescale 1ns/1ps
interface dacoc_chan_if;
  logic [15:0] ctl;
  logic [15:0] dat;
  logic loadEvt;
  logic [11:0] coreCode;
  logic latched;
  modport top (output ctl, output dat, output loadEvt,
    input coreCode, input latched);
  modport chan (input ctl, input dat, input loadEvt,
    output coreCode, output latched);
endinterface : dacoc_chan_if

// File: hw/dacoc_chan.sv
/*
 One converter instance: masking, format, data latch.
 Assumes load events are single-cycle pulses in the bus clock domain.
*/
`timescale 1ns/1ps
module dacoc_chan
  import dacoc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  dacoc_chan_if.chan ch
);
  typedef struct packed {
    logic [11:0] latch;
    logic latched;
  } dacoc_chan_type;
  dacoc_chan_type st_ff, nxt_st;
  logic [11:0] raw;
  logic [11:0] sgn;
  logic [11:0] msk;

  always_comb begin
    msk = ch.ctl[RES_BIT] ? MASK8 : MASK12;
    raw = ch.dat[11:0] & msk;
    sgn = ch.ctl[RES_BIT] ? SIGN8 : SIGN12;
    if (ch.ctl[DF_BIT]) begin
      raw = raw ^ sgn;
    end
    nxt_st = st_ff;
    nxt_st.latched = 1'b0;
    if (ch.loadEvt) begin
      nxt_st.latch = raw;
      nxt_st.latched = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Transparent mode bypasses the latch
  // Latched word is masked again in case resolution changed since
  assign ch.coreCode = (ch.ctl[LSEL_LSB +: 2] == LSEL_NONE) ? raw
    : (st_ff.latch & msk);
  assign ch.latched = st_ff.latched;
endmodule : dacoc_chan

// File: hw/dacoc_top.sv
/*
 APB-reached control for one or two voltage-output converters.
 Assumes timer compare inputs come from pins, so they are synchronised.
*/
`timescale 1ns/1ps
module dacoc_top
  import dacoc_pkg::*;
#(
  parameter int NINST = NUM_INST,
  parameter bit SUPPLY_REF = 1'b0,
  parameter bit SINGLE_PIN = 1'b0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tmrCmp1,
  input wire logic tmrCmp2,
  output logic [23:0] coreCodeOut,
  output logic [1:0] rangeTimes3,
  output logic [1:0] refExternal,
  output logic [5:0] bufferAmpSetting,
  output logic [1:0] pinOnGeneral,
  output logic [1:0] pinOnAlternate,
  output logic irq
);
  typedef struct packed {
    logic [1:0][15:0] ctl;
    logic [1:0][15:0] dat;
    logic [1:0] written;
    logic [1:0] tsync1;
    logic [1:0] tsync2;
    logic [1:0] tprev;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [23:0] code;
    logic [1:0] rng;
    logic [1:0] rext;
    logic [5:0] amp;
    logic [1:0] pgen;
    logic [1:0] palt;
    logic irq;
  } dacoc_top_type;
  dacoc_top_type st_ff, nxt_st;

  dacoc_chan_if chIf[2] ();
  logic [1:0] loadEvt;
  logic [1:0] wrDat;
  logic [1:0] tmrRise;
  logic wrAcc;
  logic [11:0] chCode [2];

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == CTL0_ADDR) || (a == DAT0_ADDR) ||
      (a == IRQ_STAT_ADDR) || (a == IRQ_MASK_ADDR) ||
      ((NINST > 1) && ((a == CTL1_ADDR) || (a == DAT1_ADDR)));
  endfunction : isMapped

  function automatic logic [1:0] lselOf(input logic [15:0] c);
    lselOf = c[LSEL_LSB +: 2];
  endfunction : lselOf

  // Writes land on the edge that completes the transfer
  assign wrAcc = psel && penable && pwrite && st_ff.ready;
  assign tmrRise = st_ff.tsync2 & ~st_ff.tprev;

  // -------------------------------------------------------------
  // Per-instance load triggers and channels
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_inst
      logic [15:0] ctlEff;
      logic [1:0] ls;
      logic trig;
      logic grp;
      // Grouped pair follows instance 0's trigger
      assign grp = (NINST > 1) && st_ff.ctl[0][GRP_BIT];
      assign ctlEff = st_ff.ctl[gi];
      assign ls = grp ? lselOf(st_ff.ctl[0]) : lselOf(ctlEff);
      assign wrDat[gi] = wrAcc && (gi < NINST) &&
        (paddr == (gi == 0 ? DAT0_ADDR : DAT1_ADDR));
      always_comb begin
        trig = 1'b0;
        case (ls)
          LSEL_WRITE: trig = grp ? (st_ff.written == 2'b11)
            : st_ff.written[gi];
          LSEL_TMR1: trig = tmrRise[0] &&
            (!grp || st_ff.written == 2'b11);
          LSEL_TMR2: trig = tmrRise[1] &&
            (!grp || st_ff.written == 2'b11);
          default: trig = 1'b0;
        endcase
      end
      assign loadEvt[gi] = trig && (gi < NINST) && ctlEff[ENC_BIT] &&
        (!grp || (st_ff.ctl[0][ENC_BIT] && st_ff.ctl[1][ENC_BIT]));
      assign chIf[gi].ctl = ctlEff;
      assign chIf[gi].dat = st_ff.dat[gi];
      assign chIf[gi].loadEvt = loadEvt[gi];
      assign chCode[gi] = chIf[gi].coreCode;
      dacoc_chan u_chan (
        .mclk(mclk),
        .rstn(rstn),
        .ch(chIf[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tsync1 = {tmrCmp2, tmrCmp1};
    nxt_st.tsync2 = st_ff.tsync1;
    nxt_st.tprev = st_ff.tsync2;
    nxt_st.ready = psel && penable && !st_ff.ready;
    nxt_st.err = 1'b0;
    if (psel && penable && !st_ff.ready) begin
      nxt_st.err = !isMapped(paddr);
      nxt_st.rdata = '0;
      if (!pwrite) begin
        case (paddr)
          CTL0_ADDR: nxt_st.rdata = {16'h0000, st_ff.ctl[0]};
          CTL1_ADDR: nxt_st.rdata = (NINST > 1) ?
            {16'h0000, st_ff.ctl[1]} : 32'h0000_0000;
          DAT0_ADDR: nxt_st.rdata = {16'h0000, st_ff.dat[0]};
          DAT1_ADDR: nxt_st.rdata = (NINST > 1) ?
            {16'h0000, st_ff.dat[1]} : 32'h0000_0000;
          IRQ_STAT_ADDR: nxt_st.rdata = {30'h0, st_ff.stat};
          IRQ_MASK_ADDR: nxt_st.rdata = {30'h0, st_ff.mask};
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (wrDat[i]) begin
        nxt_st.dat[i] = pwdata[15:0];
        nxt_st.written[i] = 1'b1;
      end else if (loadEvt[i] || !st_ff.ctl[i][ENC_BIT]) begin
        // Writes made while disabled never trigger a later load
        nxt_st.written[i] = 1'b0;
      end
      if (wrAcc && paddr == (i == 0 ? CTL0_ADDR : CTL1_ADDR) &&
          i < NINST) begin
        // Locked fields keep value while enabled
        if (st_ff.ctl[i][ENC_BIT]) begin
          nxt_st.ctl[i] = {st_ff.ctl[i][15:9], pwdata[8],
            st_ff.ctl[i][7:5], pwdata[4:0]};
        end else begin
          nxt_st.ctl[i] = pwdata[15:0];
        end
      end
      if (loadEvt[i] && lselOf(st_ff.ctl[i]) != LSEL_NONE) begin
        nxt_st.ctl[i][IFG_BIT] = 1'b1;
        nxt_st.stat[i] = 1'b1;
      end else if (wrAcc && paddr == IRQ_STAT_ADDR && pwdata[i]) begin
        nxt_st.stat[i] = 1'b0;
      end
      // Core view of each instance
      nxt_st.code[i*12 +: 12] = (i < NINST) ? chCode[i]
        : 12'h000;
      nxt_st.rng[i] = !st_ff.ctl[i][IR_BIT];
      nxt_st.rext[i] = SUPPLY_REF ? st_ff.ctl[i][SREF_LSB + 1]
        : st_ff.ctl[i][SREF_LSB + 1];
      nxt_st.amp[i*3 +: 3] = st_ff.ctl[i][AMP_LSB +: 3];
      if (SINGLE_PIN) begin
        nxt_st.pgen[i] = 1'b0;
        nxt_st.palt[i] = st_ff.ctl[i][OPS_BIT];
      end else begin
        nxt_st.pgen[i] = (st_ff.ctl[i][AMP_LSB +: 3] != 3'h0) &&
          !st_ff.ctl[i][OPS_BIT];
        nxt_st.palt[i] = (st_ff.ctl[i][AMP_LSB +: 3] != 3'h0) &&
          st_ff.ctl[i][OPS_BIT];
      end
    end
    if (wrAcc && paddr == IRQ_MASK_ADDR) begin
      nxt_st.mask = pwdata[1:0];
    end
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign coreCodeOut = st_ff.code;
  assign rangeTimes3 = st_ff.rng;
  assign refExternal = st_ff.rext;
  assign bufferAmpSetting = st_ff.amp;
  assign pinOnGeneral = st_ff.pgen;
  assign pinOnAlternate = st_ff.palt;
  assign irq = st_ff.irq;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_rng;
    @(posedge mclk) disable iff (!rstn)
    rstn |=> rangeTimes3[0] == !$past(st_ff.ctl[0][IR_BIT]);
  endproperty
  a_rng: assert property (p_rng) else $error("range");
  property p_flag;
    @(posedge mclk) disable iff (!rstn)
    loadEvt[0] |=> st_ff.stat[0];
  endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_enc;
    @(posedge mclk) disable iff (!rstn)
    !st_ff.ctl[0][ENC_BIT] |-> !loadEvt[0];
  endproperty
  a_enc: assert property (p_enc) else $error("enc");
  property p_grp;
    @(posedge mclk) disable iff (!rstn)
    (st_ff.ctl[0][GRP_BIT] && st_ff.written != 2'b11) |-> !loadEvt[0];
  endproperty
  a_grp: assert property (p_grp) else $error("grp");
  property p_mask;
    @(posedge mclk) disable iff (!rstn)
    st_ff.ctl[0][RES_BIT] |-> chIf[0].coreCode[11:8] == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_pin;
    @(posedge mclk) disable iff (!rstn)
    (st_ff.ctl[0][AMP_LSB +: 3] == 3'h0 && !SINGLE_PIN) |=>
      !pinOnGeneral[0] && !pinOnAlternate[0];
  endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_irq;
    @(posedge mclk) disable iff (!rstn)
    1 |-> irq == |(st_ff.stat & st_ff.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_rdy;
    @(posedge mclk) disable iff (!rstn)
    (psel && !penable) ##1 (psel && penable) |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_thru;
    @(posedge mclk) disable iff (!rstn)
    (lselOf(st_ff.ctl[0]) == LSEL_NONE && !st_ff.ctl[0][RES_BIT] &&
      !st_ff.ctl[0][DF_BIT]) |-> chCode[0] == st_ff.dat[0][11:0];
  endproperty
  a_thru: assert property (p_thru) else $error("transparent");
  property p_res8;
    @(posedge mclk) disable iff (!rstn)
    (lselOf(st_ff.ctl[0]) == LSEL_NONE && st_ff.ctl[0][RES_BIT] &&
      !st_ff.ctl[0][DF_BIT]) |-> chCode[0] == {4'h0, st_ff.dat[0][7:0]};
  endproperty
  a_res8: assert property (p_res8) else $error("res8");
  property p_fmt;
    @(posedge mclk) disable iff (!rstn)
    (lselOf(st_ff.ctl[0]) == LSEL_NONE && !st_ff.ctl[0][RES_BIT] &&
      st_ff.ctl[0][DF_BIT]) |->
      chCode[0] == {~st_ff.dat[0][11], st_ff.dat[0][10:0]};
  endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_gen;
    @(posedge mclk) disable iff (!rstn)
    (!SINGLE_PIN && st_ff.ctl[0][AMP_LSB +: 3] != 3'h0 &&
      !st_ff.ctl[0][OPS_BIT]) |=> pinOnGeneral[0] && !pinOnAlternate[0];
  endproperty
  a_gen: assert property (p_gen) else $error("general");
  property p_alt;
    @(posedge mclk) disable iff (!rstn)
    (!SINGLE_PIN && st_ff.ctl[0][AMP_LSB +: 3] != 3'h0 &&
      st_ff.ctl[0][OPS_BIT]) |=> pinOnAlternate[0] && !pinOnGeneral[0];
  endproperty
  a_alt: assert property (p_alt) else $error("alternate");
  property p_ref;
    @(posedge mclk) disable iff (!rstn)
    rstn |=> refExternal[0] == $past(st_ff.ctl[0][SREF_LSB + 1]);
  endproperty
  a_ref: assert property (p_ref) else $error("ref");
  property p_lock;
    @(posedge mclk) disable iff (!rstn)
    st_ff.ctl[0][ENC_BIT] |=> st_ff.ctl[0][15:9] == $past(st_ff.ctl[0][15:9]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_grp1;
    @(posedge mclk) disable iff (!rstn)
    (NINST > 1 && st_ff.ctl[0][GRP_BIT]) |-> loadEvt[0] == loadEvt[1];
  endproperty
  a_grp1: assert property (p_grp1) else $error("group");
  property p_clr;
    @(posedge mclk) disable iff (!rstn)
    (wrAcc && paddr == IRQ_STAT_ADDR && pwdata[0] && !loadEvt[0]) |=>
      !st_ff.stat[0];
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_nf;
    @(posedge mclk) disable iff (!rstn)
    (lselOf(st_ff.ctl[0]) == LSEL_NONE && !st_ff.stat[0]) |=>
      !st_ff.stat[0];
  endproperty
  a_nf: assert property (p_nf) else $error("no flag");
  property p_rdy1;
    @(posedge mclk) disable iff (!rstn)
    pready |=> !pready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready pulse");
  property p_err;
    @(posedge mclk) disable iff (!rstn)
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error");
  c_load: cover property (@(posedge mclk) chIf[0].latched);
  c_grp: cover property (@(posedge mclk) loadEvt == 2'b11);
  c_irq: cover property (@(posedge mclk) irq);
  c_tmr: cover property (@(posedge mclk) |tmrRise);
endmodule : dacoc_top

// File: verif/tb_top.sv
/*
 Self-checking bench for the converter output control block.
 Assumes the design package and top module are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
  import dacoc_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq;
  logic tmrCmp1 = 1'b0;
  logic tmrCmp2 = 1'b0;
  logic [23:0] coreCodeOut;
  logic [1:0] rangeTimes3, refExternal, pinOnGeneral, pinOnAlternate;
  logic [5:0] bufferAmpSetting;
  logic [11:0] regs [6];
  int bad_count = 0;
  int cmp_count = 0;
  int ctl [2];
  int dat [2];
  int lat [2];
  int pend [2];
  int stat, msk, i, r;

  always #4 mclk = ~mclk;

  dacoc_top uut (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmrCmp1(tmrCmp1), .tmrCmp2(tmrCmp2), .coreCodeOut(coreCodeOut),
    .rangeTimes3(rangeTimes3), .refExternal(refExternal),
    .bufferAmpSetting(bufferAmpSetting), .pinOnGeneral(pinOnGeneral),
    .pinOnAlternate(pinOnAlternate), .irq(irq));

  // ---------------------------------------------------------------
  // Compare, bus and model tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    if (n >= 20) bad_count++;
    chk(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic int lsel(input int k);
    return (ctl[k] >> 10) & 3;
  endfunction : lsel

  task automatic latch(input int k);
    lat[k] = conv(k);
    stat |= 1 << k;
  endtask : latch

  task automatic load(input int k);
    if (ctl[0][0] && lsel(0) > 0 && lsel(1) > 0) begin
      pend[k] = 1;
      if (lsel(0) == 1 && pend[0] && pend[1] && ctl[0][1] && ctl[1][1])
      begin
        latch(0);
        latch(1);
        pend = '{0, 0};
      end
    end else if (lsel(k) == 1 && ctl[k][1]) latch(k);
  endtask : load

  task automatic wr(input logic [11:0] a, input int d);
    int k;
    apb(1'b1, a, d, 1'b0);
    k = (a == CTL1_ADDR || a == DAT1_ADDR);
    if (a == CTL0_ADDR || a == CTL1_ADDR) begin
      if (ctl[k][1]) ctl[k] = (ctl[k] & 16'hfee4) | (d & 16'h011b);
      else ctl[k] = d & 16'hfffb;
    end else if (a == DAT0_ADDR || a == DAT1_ADDR) begin
      dat[k] = d & 16'hffff;
      load(k);
    end else if (a == IRQ_STAT_ADDR) stat &= ~d;
    else if (a == IRQ_MASK_ADDR) msk = d & 3;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
    input logic err);
    apb(1'b0, a, 32'h0000_0000, err);
    chk(rd, e);
  endtask : rdc

  function automatic int rctl(input int k);
    return ctl[k] | (((stat >> k) & 1) << 2);
  endfunction : rctl

  function automatic logic [11:0] conv(input int k);
    int m;
    m = ctl[k][12] ? MASK8 : MASK12;
    return (dat[k] & m) ^ (ctl[k][4] ? (ctl[k][12] ? SIGN8 : SIGN12) : 0);
  endfunction : conv

  function automatic logic [11:0] code(input int k);
    int m;
    m = ctl[k][12] ? MASK8 : MASK12;
    if (lsel(k) == 0) return conv(k);
    return lat[k] & m;
  endfunction : code

  task automatic outs;
    repeat (6) @(posedge mclk);
    for (int k = 0; k < 2; k++) begin
      chk(coreCodeOut[k*12 +: 12], code(k));
      chk(rangeTimes3[k], !ctl[k][8]);
      chk(refExternal[k], ctl[k][14]);
      chk(bufferAmpSetting[k*3 +: 3], ctl[k][7:5]);
      chk(pinOnGeneral[k], ctl[k][7:5] != 0 && !ctl[k][15]);
      chk(pinOnAlternate[k], ctl[k][7:5] != 0 && ctl[k][15]);
    end
    chk(irq, (stat & msk) != 0);
  endtask : outs

  task automatic pulse(input int t);
    if (t == 0) tmrCmp1 <= 1'b1;
    else tmrCmp2 <= 1'b1;
    repeat (4) @(posedge mclk);
    tmrCmp1 <= 1'b0;
    tmrCmp2 <= 1'b0;
    for (int k = 0; k < 2; k++)
      if (lsel(k) == t + 2 && ctl[k][1]) latch(k);
    outs;
  endtask : pulse

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end

  initial begin
    regs = '{CTL0_ADDR, CTL1_ADDR, DAT0_ADDR, DAT1_ADDR, IRQ_STAT_ADDR,
      IRQ_MASK_ADDR};
    void'($urandom(32'h7d9d_d5b1));
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    foreach (regs[j]) rdc(regs[j], 32'h0000_0000, 1'b0);
    outs;
    rdc(12'h1d8, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h3fc, $urandom, 1'b1);
    for (i = 0; i < 24; i++) begin
      wr(regs[i%2], $urandom & 16'hf1f0);
      wr(regs[2+i%2], $urandom);
      rdc(regs[i%2], rctl(i%2), 1'b0);
      rdc(regs[2+i%2], dat[i%2], 1'b0);
      outs;
    end
    wr(IRQ_MASK_ADDR, 3);
    wr(CTL0_ADDR, 16'h0402);
    wr(CTL0_ADDR, 16'h1012);
    rdc(CTL0_ADDR, rctl(0), 1'b0);
    wr(DAT0_ADDR, $urandom);
    outs;
    rdc(IRQ_STAT_ADDR, stat, 1'b0);
    wr(IRQ_STAT_ADDR, 1);
    outs;
    wr(CTL0_ADDR, 16'h0400);
    wr(DAT0_ADDR, $urandom);
    outs;
    for (int t = 0; t < 2; t++) begin
      wr(CTL1_ADDR, 0);
      wr(CTL1_ADDR, (t + 2) * 16'h0400 + 2);
      wr(DAT1_ADDR, $urandom);
      outs;
      pulse(1 - t);
      pulse(t);
    end
    wr(IRQ_STAT_ADDR, 3);
    wr(CTL1_ADDR, 0);
    wr(CTL0_ADDR, 16'h0403);
    wr(CTL1_ADDR, 16'h0402);
    wr(DAT0_ADDR, $urandom);
    outs;
    wr(DAT1_ADDR, dat[1]);
    outs;
    rdc(IRQ_STAT_ADDR, stat, 1'b0);
    wrap_up;
  end
endmodule : tb_top
